// File: verilog/cra_adder.sv
// Purpose: adds up to three rotated, scaled I/Q streams of other channels onto own stream
// Assumes: all source streams are sample aligned with the own stream on clk
// Notes: rotation resolution is 1/64 turn; gain q2.14; combined output clamped to +-full scale, bypass passes own samples unclamped
//
// Contract
// - A combiner enable of 1 adds routed signals onto the output and 0 turns adding off.
// - A readable count of overflow events is kept whenever the sum exceeds full scale.
// - Each route takes the I/Q samples of the channel named by its source index.
// - A route whose source is this channel's own index is refused.
// - Each routed signal is multiplied by its own gain before being added.
// - Each route rotates its signal by its own phase, which wraps modulo one turn.
// - Output I and Q are own I and Q plus the sum of gain times the rotated source I and Q.
// - The routed data are the modulated I/Q streams before digital-to-analog conversion.
// - There are three routes, each with its own enable, source, gain and rotation.
// - When the sum overflows, summed samples are clamped to the range minus one to plus one.
// - Each gain and rotation setting arrives as a 16-bit fixed-point word.
// - Only waveform I/Q samples are routed, never marker or trigger data.
`timescale 1ns/1ps
module cra_adder #(
  parameter int NUM_CH = cra_pkg::NUM_CH,
  parameter int OWN_IDX = 0,
  parameter int IDX_W = 3
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic comb_en,
  input wire logic [cra_pkg::NUM_ROUTES-1:0] route_en,
  input wire logic [cra_pkg::NUM_ROUTES*IDX_W-1:0] route_src,
  input wire logic [cra_pkg::NUM_ROUTES*cra_pkg::CFG_W-1:0] path_gain,
  input wire logic [cra_pkg::NUM_ROUTES*cra_pkg::CFG_W-1:0] path_rotation,
  input wire logic own_valid,
  output logic own_ready,
  input wire logic [cra_pkg::SAMPLE_W-1:0] own_i,
  input wire logic [cra_pkg::SAMPLE_W-1:0] own_q,
  input wire logic [NUM_CH*cra_pkg::SAMPLE_W-1:0] src_i,
  input wire logic [NUM_CH*cra_pkg::SAMPLE_W-1:0] src_q,
  output logic dac_valid,
  input wire logic dac_ready,
  output logic [cra_pkg::SAMPLE_W-1:0] dac_i,
  output logic [cra_pkg::SAMPLE_W-1:0] dac_q,
  output logic [cra_pkg::NUM_ROUTES-1:0] route_active,
  output logic cfg_reject,
  output logic [cra_pkg::CNT_W-1:0] ovf_count,
  output logic ovf_seen,
  input wire logic ovf_clear
);
  localparam int R = cra_pkg::NUM_ROUTES;
  localparam int SW = cra_pkg::SAMPLE_W;
  localparam int CW = cra_pkg::CFG_W;
  localparam int XW = cra_pkg::SUM_W;
  localparam logic signed [XW-1:0] POS_LIM = {{(XW-SW){1'b0}}, cra_pkg::FULL_SCALE};
  localparam logic signed [XW-1:0] NEG_LIM = -POS_LIM;

  // quarter-wave sine; coarse on purpose, trading phase resolution for area
  function automatic logic signed [SW-1:0] quarter_tab(input logic [4:0] k);
    unique case (k)
      5'h00: quarter_tab = 16'sh0000;
      5'h01: quarter_tab = 16'sh0c8c;
      5'h02: quarter_tab = 16'sh18f9;
      5'h03: quarter_tab = 16'sh2528;
      5'h04: quarter_tab = 16'sh30fb;
      5'h05: quarter_tab = 16'sh3c56;
      5'h06: quarter_tab = 16'sh471c;
      5'h07: quarter_tab = 16'sh5133;
      5'h08: quarter_tab = 16'sh5a82;
      5'h09: quarter_tab = 16'sh62f1;
      5'h0a: quarter_tab = 16'sh6a6d;
      5'h0b: quarter_tab = 16'sh70e2;
      5'h0c: quarter_tab = 16'sh7641;
      5'h0d: quarter_tab = 16'sh7a7c;
      5'h0e: quarter_tab = 16'sh7d89;
      5'h0f: quarter_tab = 16'sh7f61;
      default: quarter_tab = 16'sh7fff;
    endcase
  endfunction : quarter_tab

  // angle in 1/64 turn; 6-bit arithmetic wraps modulo a full turn
  function automatic logic signed [SW-1:0] sine64(input logic [5:0] a);
    logic [4:0] k;
    logic signed [SW-1:0] m;
    k = a[4] ? 5'h10 - {1'b0, a[3:0]} : {1'b0, a[3:0]};
    m = quarter_tab(k);
    sine64 = a[5] ? -m : m;
  endfunction : sine64

  logic [R-1:0] act;
  logic [R-1:0] dup;
  logic [R-1:0] self_hit;
  logic signed [XW-1:0] contrib_i [R];
  logic signed [XW-1:0] contrib_q [R];
  logic signed [XW-1:0] sum_i;
  logic signed [XW-1:0] sum_q;
  logic [SW-1:0] next_i;
  logic [SW-1:0] next_q;
  logic ovf_now;
  logic fire;
  logic fifo_in_ready;

  // route admission: own index and out-of-range refused, later duplicate refused
  always_comb
  begin
    for (int r = 0; r < R; r++)
    begin
      self_hit[r] = (int'(route_src[r*IDX_W +: IDX_W]) == OWN_IDX)
        || (int'(route_src[r*IDX_W +: IDX_W]) >= NUM_CH);
      dup[r] = 1'b0;
      for (int p = 0; p < r; p++)
      begin
        if (route_en[p] && route_src[p*IDX_W +: IDX_W] == route_src[r*IDX_W +: IDX_W])
        begin
          dup[r] = 1'b1;
        end
      end
      act[r] = comb_en && route_en[r] && !self_hit[r] && !dup[r];
    end
  end

  assign route_active = act;
  assign cfg_reject = |(route_en & (self_hit | dup));

  generate
    for (genvar g = 0; g < R; g++)
    begin : g_route
      logic signed [SW-1:0] si;
      logic signed [SW-1:0] sq;
      logic [5:0] ang;
      logic signed [SW-1:0] s_v;
      logic signed [SW-1:0] c_v;
      logic signed [2*SW:0] rot_i;
      logic signed [2*SW:0] rot_q;
      logic signed [2*SW+CW+1:0] sc_i;
      logic signed [2*SW+CW+1:0] sc_q;

      // source pick; only waveform samples exist on these buses
      always_comb
      begin
        si = '0;
        sq = '0;
        for (int c = 0; c < NUM_CH; c++)
        begin
          if (int'(route_src[g*IDX_W +: IDX_W]) == c)
          begin
            si = src_i[c*SW +: SW];
            sq = src_q[c*SW +: SW];
          end
        end
      end

      assign ang = path_rotation[g*CW + CW - 1 -: cra_pkg::ROT_LUT_BITS];
      assign s_v = sine64(ang);
      assign c_v = sine64(ang + cra_pkg::QUARTER_TURN);
      assign rot_i = (2*SW+1)'(si * c_v) - (2*SW+1)'(sq * s_v);
      assign rot_q = (2*SW+1)'(si * s_v) + (2*SW+1)'(sq * c_v);
      assign sc_i = rot_i * $signed(path_gain[g*CW +: CW]);
      assign sc_q = rot_q * $signed(path_gain[g*CW +: CW]);
      // disabled or refused route adds nothing
      assign contrib_i[g] = act[g]
        ? XW'(sc_i >>> (cra_pkg::TRIG_FRAC + cra_pkg::GAIN_FRAC)) : '0;
      assign contrib_q[g] = act[g]
        ? XW'(sc_q >>> (cra_pkg::TRIG_FRAC + cra_pkg::GAIN_FRAC)) : '0;
    end
  endgenerate

  always_comb
  begin
    sum_i = {{(XW-SW){own_i[SW-1]}}, own_i};
    sum_q = {{(XW-SW){own_q[SW-1]}}, own_q};
    for (int r = 0; r < R; r++)
    begin
      sum_i = sum_i + contrib_i[r];
      sum_q = sum_q + contrib_q[r];
    end
  end

  assign ovf_now = comb_en && (sum_i > POS_LIM || sum_i < NEG_LIM
    || sum_q > POS_LIM || sum_q < NEG_LIM);

  // clamping is applied to every combined sample, so the first overflow is clipped too
  always_comb
  begin
    if (!comb_en)
    begin
      next_i = own_i;
      next_q = own_q;
    end
    else
    begin
      next_i = (sum_i > POS_LIM) ? POS_LIM[SW-1:0]
        : (sum_i < NEG_LIM) ? NEG_LIM[SW-1:0] : sum_i[SW-1:0];
      next_q = (sum_q > POS_LIM) ? POS_LIM[SW-1:0]
        : (sum_q < NEG_LIM) ? NEG_LIM[SW-1:0] : sum_q[SW-1:0];
    end
  end

  assign own_ready = fifo_in_ready;
  assign fire = own_valid && fifo_in_ready;

  // counter saturates; a new event in the clearing cycle is kept
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ovf_count <= cra_pkg::CNT_RESET;
    end
    else if (fire && ovf_now)
    begin
      if (ovf_clear)
      begin
        ovf_count <= cra_pkg::CNT_RESET + 1'b1;
      end
      else if (ovf_count != cra_pkg::CNT_MAX)
      begin
        ovf_count <= ovf_count + 1'b1;
      end
    end
    else if (ovf_clear)
    begin
      ovf_count <= cra_pkg::CNT_RESET;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ovf_seen <= 1'b0;
    end
    else if (fire && ovf_now)
    begin
      ovf_seen <= 1'b1;
    end
    else if (ovf_clear)
    begin
      ovf_seen <= 1'b0;
    end
  end

  cra_fifo #(
    .WIDTH(2*SW),
    .DEPTH(cra_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .srst(srst),
    .in_valid(own_valid),
    .in_ready(fifo_in_ready),
    .in_data({next_i, next_q}),
    .out_valid(dac_valid),
    .out_ready(dac_ready),
    .out_data({dac_i, dac_q})
  );

  a_bypass_exact: assert property (@(posedge clk) disable iff (srst)
    fire && !comb_en |-> next_i == own_i && next_q == own_q && act == '0)
    else $error("disabled combiner altered own stream");
  a_no_route_pass: assert property (@(posedge clk) disable iff (srst)
    fire && comb_en && act == '0 |-> next_i == own_i && next_q == own_q && !ovf_now)
    else $error("idle routes changed the sample");
  a_own_src_block: assert property (@(posedge clk) disable iff (srst)
    route_src[IDX_W-1:0] == IDX_W'(OWN_IDX) |-> !act[0] && !route_active[0])
    else $error("own index accepted as source");
  a_dup_src_block: assert property (@(posedge clk) disable iff (srst)
    act[0] && act[1] |-> route_src[IDX_W-1:0] != route_src[2*IDX_W-1:IDX_W])
    else $error("two routes share one source");
  a_clamp_range: assert property (@(posedge clk) disable iff (srst)
    fire && comb_en && sum_i > POS_LIM |-> next_i == cra_pkg::FULL_SCALE && ovf_now)
    else $error("positive overflow not clamped");
  a_count_step: assert property (@(posedge clk) disable iff (srst)
    fire && ovf_now && !ovf_clear && ovf_count != cra_pkg::CNT_MAX
    |=> ovf_count == $past(ovf_count) + 1'b1 && ovf_seen)
    else $error("overflow not counted");
  a_count_clear: assert property (@(posedge clk) disable iff (srst)
    ovf_clear && !(fire && ovf_now) |=> ovf_count == '0 ##1 ovf_count <= 32'h1)
    else $error("overflow count not cleared");
endmodule : cra_adder

// File: verilog/cra_pkg.sv
// Purpose: shared constants for the cross channel route adder
// Assumes: samples and settings are two's complement fixed point
// Notes: full scale +-1.0 maps to +-FULL_SCALE on the sample bus
package cra_pkg;
  localparam int SAMPLE_W = 16;
  localparam int CFG_W = 16;
  localparam int NUM_ROUTES = 3;
  localparam int NUM_CH = 6;
  // gain is q2.14 (0x4000 = 1.0), trig table is q1.15
  localparam int GAIN_FRAC = 14;
  localparam int TRIG_FRAC = 15;
  // rotation: full 16-bit word is one turn, top bits address the table
  localparam int ROT_LUT_BITS = 6;
  localparam logic [5:0] QUARTER_TURN = 6'h10;
  localparam int SUM_W = 24;
  localparam logic [SAMPLE_W-1:0] FULL_SCALE = 16'h7fff;
  localparam int CNT_W = 32;
  localparam logic [CNT_W-1:0] CNT_RESET = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_MAX = 32'hffff_ffff;
  localparam int FIFO_DEPTH = 8;
endpackage : cra_pkg

// File: verilog/cra_fifo.sv
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: single clock, synchronous active-high reset
// Notes: out_data is read from the flop array, no extra latency
`timescale 1ns/1ps
module cra_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = cra_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = (AW)'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] level;
  logic push;
  logic pop;

  assign in_ready = (level != DEPTH_CNT);
  assign out_valid = (level != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop)
      begin
        level <= level + 1'b1;
      end
      else if (pop && !push)
      begin
        level <= level - 1'b1;
      end
    end
  end

  a_fifo_hold: assert property (@(posedge clk) disable iff (srst)
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("fifo output changed while stalled");
endmodule : cra_fifo

// File: test/cra_dac_model.sv
// Purpose: converter-side sink that takes combined output samples
// Assumes: one sample per edge with dac_valid and dac_ready high
// Notes: stall holds ready low so the fifo backs up
`timescale 1ns/1ps
module cra_dac_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic stall,
  input wire logic dac_valid,
  output logic dac_ready,
  input wire logic [cra_pkg::SAMPLE_W-1:0] dac_i,
  input wire logic [cra_pkg::SAMPLE_W-1:0] dac_q
);
  logic [31:0] got [$];
  // a converter never refuses by itself, only during reset or when the bench asks for a stall
  assign dac_ready = !stall && !srst;
  always @(posedge clk)
  begin
    if (dac_valid && dac_ready)
    begin
      got.push_back({dac_i, dac_q});
    end
  end
endmodule : cra_dac_model

// File: test/test_cross_channel_iq_route_adder.sv
// Purpose: self-checking bench for the route adder
// Assumes: this channel is index 0; trig peaks taken as 32767
// Notes: rotation tests stay on table points that are exact
`timescale 1ns/1ps
module test_cross_channel_iq_route_adder;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic comb_en = 1'b0;
  logic [2:0] route_en = 3'h0;
  logic [8:0] route_src = 9'h000;
  logic [47:0] path_gain = 48'h0;
  logic [47:0] path_rotation = 48'h0;
  logic own_valid = 1'b0;
  logic [15:0] own_i = 16'h0000;
  logic [15:0] own_q = 16'h0000;
  logic [15:0] si [6];
  logic [15:0] sq [6];
  logic [95:0] src_i;
  logic [95:0] src_q;
  logic stall = 1'b0;
  logic ovf_clear = 1'b0;
  logic own_ready, dac_valid, dac_ready, cfg_reject, ovf_seen;
  logic [15:0] dac_i, dac_q;
  logic [2:0] route_active;
  logic [31:0] ovf_count;
  int failures = 0;
  int n_tests = 0;
  always #5 clk = ~clk;
  always_comb
  begin
    for (int c = 0; c < 6; c++)
    begin
      src_i[16*c+:16] = si[c];
      src_q[16*c+:16] = sq[c];
    end
  end
  cra_adder cra_adder_inst (.clk(clk), .srst(srst), .comb_en(comb_en), .route_en(route_en),
    .route_src(route_src), .path_gain(path_gain), .path_rotation(path_rotation),
    .own_valid(own_valid), .own_ready(own_ready), .own_i(own_i), .own_q(own_q),
    .src_i(src_i), .src_q(src_q), .dac_valid(dac_valid), .dac_ready(dac_ready),
    .dac_i(dac_i), .dac_q(dac_q), .route_active(route_active), .cfg_reject(cfg_reject),
    .ovf_count(ovf_count), .ovf_seen(ovf_seen), .ovf_clear(ovf_clear));
  cra_dac_model cra_dac_model_inst (.clk(clk), .srst(srst), .stall(stall),
    .dac_valid(dac_valid), .dac_ready(dac_ready), .dac_i(dac_i), .dac_q(dac_q));
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out
  task automatic chk_word(input string name, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, e, g);
    end
  endtask : chk_word
  task automatic chk_flag(input string name, input logic [3:0] e, input logic [3:0] g);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %b seen %b", name, e, g);
    end
  endtask : chk_flag
  function automatic int ctr(input int a, input int b, input int c, input int s, input int g);
    longint p;
    p = longint'(a * c - b * s) * g;
    return int'(p >>> 29);
  endfunction : ctr
  function automatic int fi(input int c, input int g);
    return ctr($signed(si[c]), $signed(sq[c]), 32767, 0, g);
  endfunction : fi
  function automatic int fq(input int c, input int g);
    return ctr($signed(sq[c]), $signed(si[c]), 32767, 0, g);
  endfunction : fq
  function automatic logic [31:0] mix(input int i, input int q);
    int v [2];
    v[0] = i;
    v[1] = q;
    for (int k = 0; k < 2; k++)
      v[k] = (v[k] > 32767) ? 32767 : ((v[k] < -32767) ? -32767 : v[k]);
    return {16'(v[0]), 16'(v[1])};
  endfunction : mix
  task automatic route(input int r, input logic e, input logic [2:0] s, input logic [15:0] g,
      input logic [15:0] p);
    route_en[r] = e;
    route_src[3*r+:3] = s;
    path_gain[16*r+:16] = g;
    path_rotation[16*r+:16] = p;
  endtask : route
  task automatic push(input logic [15:0] i, input logic [15:0] q);
    @(negedge clk);
    own_i = i;
    own_q = q;
    own_valid = 1'b1;
    while (own_ready !== 1'b1)
      @(negedge clk);
    @(negedge clk);
    own_valid = 1'b0;
  endtask : push
  task automatic pull(input string name, input logic [31:0] e);
    logic [31:0] g;
    g = 32'hxxxxxxxx;
    for (int k = 0; k < 40 && cra_dac_model_inst.got.size() == 0; k++)
      @(negedge clk);
    if (cra_dac_model_inst.got.size() > 0)
      g = cra_dac_model_inst.got.pop_front();
    chk_word(name, e, g);
  endtask : pull
  task automatic t_bypass();
    comb_en = 1'b0;
    route(0, 1'b1, 3'h2, 16'h4000, 16'h0000);
    push(16'h1234, 16'h8765);
    pull("bypass", 32'h1234_8765);
    chk_flag("bypass act", 4'h0, {cfg_reject, route_active});
  endtask : t_bypass
  task automatic t_select();
    comb_en = 1'b1;
    for (int s = 1; s < 6; s++)
    begin
      route(0, 1'b1, 3'(s), 16'h4000, 16'h0000);
      push(16'h0100, 16'h0200);
      pull("select", mix(256 + fi(s, 16384), 512 + fq(s, 16384)));
    end
  endtask : t_select
  task automatic t_rotate();
    int x;
    int y;
    x = $signed(si[4]);
    y = $signed(sq[4]);
    // low bits below the table step are ignored; at three quarters the cosine wraps past a turn
    route(0, 1'b1, 3'h4, 16'h4000, 16'h4000);
    push(16'h0000, 16'h0000);
    pull("quarter", mix(ctr(x, y, 0, 32767, 16384), ctr(y, x, 0, -32767, 16384)));
    route(0, 1'b1, 3'h4, 16'h4000, 16'hc03f);
    push(16'h0000, 16'h0000);
    pull("wrap", mix(ctr(x, y, 0, -32767, 16384), ctr(y, x, 0, 32767, 16384)));
  endtask : t_rotate
  task automatic t_gain();
    route(0, 1'b1, 3'h1, 16'h2000, 16'h0000);
    route(1, 1'b1, 3'h2, 16'he000, 16'h0000);
    route(2, 1'b0, 3'h3, 16'h4000, 16'h0000);
    push(16'h0010, 16'hfff0);
    pull("two routes", mix(16 + fi(1, 8192) + fi(2, -8192), -16 + fq(1, 8192) + fq(2, -8192)));
    chk_flag("two act", 4'h3, {cfg_reject, route_active});
    route_en[2] = 1'b1;
    push(16'h0010, 16'hfff0);
    pull("three", mix(16 + fi(1, 8192) + fi(2, -8192) + fi(3, 16384),
      -16 + fq(1, 8192) + fq(2, -8192) + fq(3, 16384)));
    chk_flag("three act", 4'h7, {cfg_reject, route_active});
  endtask : t_gain
  task automatic t_reject();
    route_en = 3'h0;
    route(0, 1'b1, 3'h0, 16'h4000, 16'h0000);
    @(negedge clk);
    chk_flag("own src", 4'h8, {cfg_reject, route_active});
    route(0, 1'b1, 3'h2, 16'h4000, 16'h0000);
    route(1, 1'b1, 3'h2, 16'h4000, 16'h0000);
    @(negedge clk);
    chk_flag("dup src", 4'h9, {cfg_reject, route_active});
    push(16'h0000, 16'h0000);
    pull("dup out", mix(fi(2, 16384), fq(2, 16384)));
    route(1, 1'b1, 3'h6, 16'h4000, 16'h0000);
    @(negedge clk);
    chk_flag("bad src", 4'h9, {cfg_reject, route_active});
    route(1, 1'b0, 3'h3, 16'h4000, 16'h0000);
  endtask : t_reject
  task automatic t_overflow();
    si[1] = 16'h7000;
    sq[1] = 16'h9000;
    route(0, 1'b1, 3'h1, 16'h4000, 16'h0000);
    for (int n = 1; n < 3; n++)
    begin
      push(16'h7000, 16'h9000);
      pull("clamp", 32'h7fff_8001);
      chk_word("ovf count", 32'(n), ovf_count);
    end
    chk_flag("ovf seen", 4'h1, {3'h0, ovf_seen});
    ovf_clear = 1'b1;
    @(negedge clk);
    ovf_clear = 1'b0;
    chk_word("ovf clear", 32'h0, ovf_count);
    chk_flag("seen clear", 4'h0, {3'h0, ovf_seen});
    // an overflow in the clearing cycle must survive the clear
    ovf_clear = 1'b1;
    push(16'h7000, 16'h9000);
    ovf_clear = 1'b0;
    pull("clamp again", 32'h7fff_8001);
    chk_word("ovf set wins", 32'h1, ovf_count);
    chk_flag("seen set wins", 4'h1, {3'h0, ovf_seen});
    si[1] = 16'h0800;
    sq[1] = 16'hfc00;
  endtask : t_overflow
  task automatic t_fifo();
    comb_en = 1'b0;
    stall = 1'b1;
    for (int k = 0; k < 8; k++)
      push(16'(k), 16'(~k));
    chk_flag("full", 4'h1, {2'h0, own_ready, dac_valid});
    stall = 1'b0;
    for (int k = 0; k < 8; k++)
      pull("drain", {16'(k), 16'(~k)});
    chk_flag("empty", 4'h2, {2'h0, own_ready, dac_valid});
  endtask : t_fifo
  initial
  begin
    #100000;
    failures++;
    close_out();
  end
  initial
  begin
    // steady sources keep the combined spectrum at dc, well inside the analog band
    for (int c = 0; c < 6; c++)
    begin
      si[c] = 16'(1024 * (c + 1));
      sq[c] = 16'(-512 * (c + 1));
    end
    repeat (4) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    chk_word("reset count", 32'h0, ovf_count);
    chk_flag("reset flags", 4'h2, {1'b0, ovf_seen, own_ready, dac_valid});
    t_bypass();
    t_select();
    t_rotate();
    t_gain();
    t_reject();
    t_overflow();
    t_fifo();
    close_out();
  end
endmodule : test_cross_channel_iq_route_adder
